/* File: bench/eit_link_checker.sv */
`timescale 1ns/100ps
// ************************************************
// Link checker between the two ends
// ************************************************
module eit_link_checker (
    input wire logic                       i_sys_clk,
    input wire logic                       i_reset_n,
    input wire logic                       irq_req,
    input wire logic                       irq_ack,
    input wire logic                       vect_rd,
    input wire logic [eit_pkg::VECT_W-1:0] vect_data,
    input wire logic                       mask_wr,
    input wire logic [eit_pkg::LVL_W-1:0]  mask_wdata,
    input wire logic [eit_pkg::LVL_W-1:0]  mask_rdata
);
    logic got_ack;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    // Remembers that some request has been accepted
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            got_ack <= 1'b0;
        end else if (irq_ack) begin
            got_ack <= 1'b1;
        end
    end

    // Accept step: offered request, then acknowledge
    sequence s_accept;
        irq_req ##1 irq_ack;
    endsequence

    a_ack_needs_req: assert property (irq_ack |-> $past(irq_req))
        else $error("acknowledge without an offered request");
    a_ack_single: assert property (irq_ack |=> !irq_ack)
        else $error("acknowledge held for two cycles");
    a_req_drop: assert property (s_accept |=> !irq_req)
        else $error("request not withdrawn after acceptance");
    a_vect_range: assert property (irq_ack |=> (vect_data[1:0] == 2'h0)
        && (vect_data >= 16'h0094) && (vect_data <= 16'h00B0))
        else $error("vector index outside the table");
    a_vect_latch: assert property ($changed(vect_data) |-> $past(irq_ack))
        else $error("vector index changed without acceptance");
    a_mask_write: assert property (mask_wr && !vect_rd |=> mask_rdata == $past(mask_wdata))
        else $error("mask write not taken");
    a_mask_load: assert property (vect_rd && got_ack |=> mask_rdata != 3'h0)
        else $error("vector read left mask at disabled level");
    a_mask_cause: assert property ($changed(mask_rdata) |-> $past(mask_wr) || $past(vect_rd))
        else $error("mask changed with no read or write");
    a_mask_blocks: assert property ((mask_rdata == 3'h7) [*3] |-> !irq_req)
        else $error("request offered above top mask level");
endmodule

/* File: bench/tb.sv */
`timescale 1ns/100ps
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin error_cnt++; \
    $display("MISMATCH t=%0t act=%0h exp=%0h", $time, (act), (exp)); end end
// ************************************************
// Testbench for both ends of the link
// ************************************************
module tb;
    logic                   i_sys_clk, i_reset_n, valid, illegal, trap, exception_return_instr, ldst;
    logic [1:0]             size, addr;
    logic [31:0]            pc, npc, redirect_pc, backup_program_counter;
    logic                   psw_wr, brk_n, vrd, mwr, redirect;
    logic [15:0]            psw_wdata, processor_status_word, vect_data;
    logic [2:0]             mwdata, mask_rdata, acc_src, ctrl_mask;
    logic [7:0]             src_req;
    logic [23:0]            src_level;
    eit_pkg::eit_cause_type cause;
    int                     error_cnt, checked;
    logic [1:0]             sz_t [5] = '{2'h1, 2'h2, 2'h0, 2'h2, 2'h1};
    logic [1:0]             ad_t [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h2};
    logic                   flt_t [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    eit_if link();
    eit_cpu_end u_eit_cpu_end (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .i_instr_valid(valid), .i_instr_illegal(illegal), .i_instr_trap(trap),
        .i_instr_rte(exception_return_instr), .i_instr_ldst(ldst), .i_ldst_size(size), .i_ldst_addr(addr),
        .i_pc(pc), .i_next_pc(npc), .i_psw_wr(psw_wr), .i_psw_wdata(psw_wdata),
        .i_sys_break_n(brk_n), .i_vect_rd(vrd), .i_mask_wr(mwr), .i_mask_wdata(mwdata),
        .o_redirect(redirect), .o_redirect_pc(redirect_pc), .o_cause(cause), .o_psw(processor_status_word),
        .o_bpc(backup_program_counter), .o_vect_data(vect_data), .o_mask_rdata(mask_rdata), .bus(link));
    eit_ctrl_end u_eit_ctrl_end (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .i_src_req(src_req), .i_src_level(src_level), .o_accepted_src(acc_src),
        .o_mask(ctrl_mask), .bus(link));
    eit_link_checker u_eit_link_checker (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .irq_req(link.irq_req), .irq_ack(link.irq_ack), .vect_rd(link.vect_rd),
        .vect_data(link.vect_data), .mask_wr(link.mask_wr),
        .mask_wdata(link.mask_wdata), .mask_rdata(link.mask_rdata));

    // ************************************************
    // Clock, watchdog and closing
    // ************************************************
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    // Cuts a hang short
    initial begin
        repeat (3000) @(posedge i_sys_clk);
        error_cnt++;
        end_of_test();
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ************************************************
    // Access tasks
    // ************************************************
    task automatic instr(input logic il, tr, rt, ls, input logic [1:0] sz, ad,
                         input logic [31:0] p);
        @(posedge i_sys_clk);
        {valid, illegal, trap, exception_return_instr, ldst} <= {1'b1, il, tr, rt, ls};
        size <= sz;
        addr <= ad;
        pc   <= p;
        npc  <= p + 32'h4;
        @(posedge i_sys_clk);
        {valid, illegal, trap, exception_return_instr, ldst} <= 5'h0;
        #1;
    endtask

    task automatic expect_jump(input eit_pkg::eit_cause_type c, input logic [31:0] t);
        `CHK(redirect, 1'b1)
        `CHK(cause, c)
        `CHK(redirect_pc, t)
    endtask

    task automatic wait_jump(input int n);
        // Step off the edge so a pulse that is just ending is not taken as new
        #1;
        for (int k = 0; k < n && redirect !== 1'b1; k++) begin
            @(posedge i_sys_clk);
            #1;
        end
    endtask

    task automatic no_jump(input int n);
        repeat (n) begin
            @(posedge i_sys_clk);
            #1;
            `CHK(redirect, 1'b0)
        end
    endtask

    task automatic pulse_sw(input logic [15:0] v, input logic [1:0] kind);
        @(posedge i_sys_clk);
        {psw_wr, vrd, mwr} <= {kind == 2'h0, kind == 2'h1, kind == 2'h2};
        psw_wdata <= v;
        mwdata    <= v[2:0];
        @(posedge i_sys_clk);
        {psw_wr, vrd, mwr} <= 3'h0;
        repeat (3) @(posedge i_sys_clk);
        #1;
    endtask

    // ************************************************
    // Test sequence
    // ************************************************
    initial begin
        {i_reset_n, valid, illegal, trap, exception_return_instr, ldst, psw_wr, vrd, mwr} = 9'h0;
        {size, addr, pc, npc, psw_wdata, mwdata, src_req, src_level} = '0;
        brk_n = 1'b1;
        repeat (20) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        valid     <= 1'b1;
        illegal   <= 1'b1;
        @(posedge i_sys_clk);
        {valid, illegal} <= 2'h0;
        #1;
        expect_jump(eit_pkg::CAUSE_RESET, eit_pkg::VEC_RESET);
        `CHK(processor_status_word, eit_pkg::PSW_RST)
        $display("Test reset done");
        pulse_sw(16'h00C1, 2'h0);
        `CHK(processor_status_word, 16'h00C1)
        instr(1'b1, 1'b1, 1'b0, 1'b1, 2'h2, 2'h2, 32'h1000);
        expect_jump(eit_pkg::CAUSE_RIE, eit_pkg::VEC_RIE);
        `CHK(backup_program_counter, 32'h1000)
        `CHK({processor_status_word[15:14], processor_status_word[8], processor_status_word[6]}, 4'hE)
        instr(1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0, 32'h2000);
        expect_jump(eit_pkg::CAUSE_RTE, 32'h1000);
        `CHK({processor_status_word[7], processor_status_word[6], processor_status_word[0]}, 3'h7)
        $display("Test illegal and return done");
        for (int i = 0; i < 5; i++) begin
            instr(1'b0, 1'b0, 1'b0, 1'b1, sz_t[i], ad_t[i], 32'h3000 + 32'(i * 4));
            `CHK(redirect, flt_t[i])
            if (flt_t[i]) begin
                expect_jump(eit_pkg::CAUSE_AE, eit_pkg::VEC_AE);
                `CHK(backup_program_counter, 32'h3000 + 32'(i * 4))
            end
        end
        instr(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 32'h4000);
        expect_jump(eit_pkg::CAUSE_TRAP, eit_pkg::VEC_TRAP);
        `CHK(backup_program_counter, 32'h4004)
        $display("Test misalign and trap done");
        @(posedge i_sys_clk);
        brk_n <= 1'b0;
        pc    <= 32'h5000;
        wait_jump(10);
        expect_jump(eit_pkg::CAUSE_SBI, eit_pkg::VEC_SBI);
        `CHK(backup_program_counter, 32'h5000)
        brk_n <= 1'b1;
        $display("Test system break done");
        pulse_sw(16'h0040, 2'h0);
        src_level[6+:3]  <= 3'h3;
        src_level[15+:3] <= 3'h5;
        src_level[18+:3] <= 3'h7;
        src_req <= 8'h24;
        pc      <= 32'h6000;
        wait_jump(10);
        expect_jump(eit_pkg::CAUSE_EI, eit_pkg::VEC_EI);
        `CHK({backup_program_counter, processor_status_word[6]}, {32'h6000, 1'b0})
        no_jump(6);
        `CHK(acc_src, 3'h5)
        pulse_sw(16'h0000, 2'h1);
        `CHK({vect_data, mask_rdata, ctrl_mask}, {16'h00A8, 3'h5, 3'h5})
        pulse_sw(16'h0040, 2'h0);
        no_jump(6);
        src_req <= 8'h64;
        pc      <= 32'h7000;
        wait_jump(10);
        expect_jump(eit_pkg::CAUSE_EI, eit_pkg::VEC_EI);
        `CHK(backup_program_counter, 32'h7000)
        pulse_sw(16'h0000, 2'h1);
        `CHK(acc_src, 3'h6)
        `CHK({vect_data, mask_rdata}, {16'h00AC, 3'h7})
        src_req <= 8'h00;
        pulse_sw(16'h0000, 2'h2);
        `CHK({mask_rdata, ctrl_mask}, {3'h0, 3'h0})
        $display("Test peripheral and nesting done");
        end_of_test();
    end
endmodule

/* File: design/eit_cpu_end.sv */
`timescale 1ns/100ps
// Contract
// - Unimplemented instruction raises illegal-opcode fault
// - Unaligned load or store raises misalign fault
// - Reset event outranks every other cause
// - Power-down or watchdog pin takes system break
// - Controller offers winner among seven enabled priority levels (1 to 7; level 0 disables)
// - Trap instruction raises software trap event
// - Non-reset event saves PC and status word
// - Jump to vector entry of the cause
// - Return restores status word and PC
// - Saved PC is faulting or following instruction
// - Stack select, enable, carry copied to saved field
// - Vector read loads source level into mask
// - Vector index holds low 16 address bits
// - Enable set admits higher nested peripheral interrupt
// - Enable clear blocks peripheral interrupts
// - Handler restores saved mask before return
// - Controller latches vector index on acceptance
module eit_cpu_end (
    input  wire logic                              i_sys_clk,
    input  wire logic                              i_reset_n,
    input  wire logic                              i_instr_valid,
    input  wire logic                              i_instr_illegal,
    input  wire logic                              i_instr_trap,
    input  wire logic                              i_instr_rte,
    input  wire logic                              i_instr_ldst,
    input  wire logic [1:0]                        i_ldst_size,
    input  wire logic [1:0]                        i_ldst_addr,
    input  wire logic [eit_pkg::PC_W-1:0]          i_pc,
    input  wire logic [eit_pkg::PC_W-1:0]          i_next_pc,
    input  wire logic                              i_psw_wr,
    input  wire logic [eit_pkg::PSW_W-1:0]         i_psw_wdata,
    input  wire logic                              i_sys_break_n,
    input  wire logic                              i_vect_rd,
    input  wire logic                              i_mask_wr,
    input  wire logic [eit_pkg::LVL_W-1:0]         i_mask_wdata,
    output logic                                   o_redirect,
    output logic [eit_pkg::PC_W-1:0]               o_redirect_pc,
    output eit_pkg::eit_cause_type                 o_cause,
    output logic [eit_pkg::PSW_W-1:0]              o_psw,
    output logic [eit_pkg::PC_W-1:0]               o_bpc,
    output logic [eit_pkg::VECT_W-1:0]             o_vect_data,
    output logic [eit_pkg::LVL_W-1:0]              o_mask_rdata,
    eit_if.cpu                                     bus
);
    // ************************************************************
    // Cause detection
    // ************************************************************
    logic                            reset_event;
    logic                            sbi_level;
    logic                            sbi_prev;
    logic                            system_break_irq;
    logic                            illegal_opcode_fault;
    logic                            misalign_fault;
    logic                            trap_event;
    logic                            peripheral_irq;
    logic                            rte_exec;
    logic                            misaligned;
    logic                            ie;
    eit_pkg::eit_cause_type          next_cause;
    logic [eit_pkg::PC_W-1:0]        next_vec;
    logic [eit_pkg::PC_W-1:0]        next_bpc;
    logic [eit_pkg::PSW_W-1:0]       psw_entry;
    logic [eit_pkg::PSW_W-1:0]       psw_return;
    logic                            take_event;

    // Filtered break pin; falling edge is the event
    eit_sync u_sbi_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_pin     (i_sys_break_n),
        .o_level   (sbi_level)
    );

    assign ie               = o_psw[eit_pkg::PSW_IE_BIT];
    assign system_break_irq = sbi_prev && !sbi_level;
    assign illegal_opcode_fault = i_instr_valid && i_instr_illegal;
    assign misaligned = ((i_ldst_size == eit_pkg::SIZE_HALF) && i_ldst_addr[0])
                     || ((i_ldst_size == eit_pkg::SIZE_WORD) && (i_ldst_addr != 2'h0));
    assign misalign_fault = i_instr_valid && !i_instr_illegal
                          && i_instr_ldst && misaligned;
    assign trap_event = i_instr_valid && !i_instr_illegal
                      && i_instr_trap;
    assign rte_exec   = i_instr_valid && !i_instr_illegal && i_instr_rte;
    // Peripheral request only while enabled
    assign peripheral_irq = bus.irq_req && ie && !bus.irq_ack;

    // ************************************************************
    // Cause priority and vector selection
    // ************************************************************
    // Reset first, then break, faults, trap, peripheral
    assign next_cause =
        reset_event          ? eit_pkg::CAUSE_RESET :
        system_break_irq     ? eit_pkg::CAUSE_SBI   :
        illegal_opcode_fault ? eit_pkg::CAUSE_RIE   :
        misalign_fault       ? eit_pkg::CAUSE_AE    :
        trap_event           ? eit_pkg::CAUSE_TRAP  :
        peripheral_irq       ? eit_pkg::CAUSE_EI    :
        rte_exec             ? eit_pkg::CAUSE_RTE   :
                               eit_pkg::CAUSE_NONE;

    assign next_vec =
        (next_cause == eit_pkg::CAUSE_RESET) ? eit_pkg::VEC_RESET :
        (next_cause == eit_pkg::CAUSE_SBI)   ? eit_pkg::VEC_SBI   :
        (next_cause == eit_pkg::CAUSE_RIE)   ? eit_pkg::VEC_RIE   :
        (next_cause == eit_pkg::CAUSE_AE)    ? eit_pkg::VEC_AE    :
        (next_cause == eit_pkg::CAUSE_TRAP)  ? eit_pkg::VEC_TRAP  :
        (next_cause == eit_pkg::CAUSE_EI)    ? eit_pkg::VEC_EI    :
                                               o_bpc;

    // Faults re-run the instruction, trap resumes after it
    assign next_bpc = (next_cause == eit_pkg::CAUSE_TRAP) ? i_next_pc : i_pc;

    assign take_event = (next_cause != eit_pkg::CAUSE_NONE)
                     && (next_cause != eit_pkg::CAUSE_RTE);

    // ************************************************************
    // Status word images on entry and on return
    // ************************************************************
    // Entry: copy SM, IE, C to saved field, then clear IE
    always_comb begin
        psw_entry = o_psw;
        psw_entry[eit_pkg::PSW_BSM_BIT] = o_psw[eit_pkg::PSW_SM_BIT];
        psw_entry[eit_pkg::PSW_BIE_BIT] = o_psw[eit_pkg::PSW_IE_BIT];
        psw_entry[eit_pkg::PSW_BC_BIT]  = o_psw[eit_pkg::PSW_C_BIT];
        psw_entry[eit_pkg::PSW_IE_BIT]  = 1'b0;
    end

    // Return: saved field back into the working bits
    always_comb begin
        psw_return = o_psw;
        psw_return[eit_pkg::PSW_SM_BIT] = o_psw[eit_pkg::PSW_BSM_BIT];
        psw_return[eit_pkg::PSW_IE_BIT] = o_psw[eit_pkg::PSW_BIE_BIT];
        psw_return[eit_pkg::PSW_C_BIT]  = o_psw[eit_pkg::PSW_BC_BIT];
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Reset event pending from reset until first clock after release
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            reset_event <= 1'b1;
            sbi_prev    <= 1'b1;
        end else begin
            reset_event <= 1'b0;
            sbi_prev    <= sbi_level;
        end
    end

    // Status word and backup PC; events override software writes
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_psw <= eit_pkg::PSW_RST;
            o_bpc <= '0;
        end else if (next_cause == eit_pkg::CAUSE_RESET) begin
            o_psw <= eit_pkg::PSW_RST;
        end else if (take_event) begin
            o_psw <= psw_entry;
            o_bpc <= next_bpc;
        end else if (rte_exec) begin
            o_psw <= psw_return;
        end else if (i_psw_wr) begin
            o_psw <= i_psw_wdata;
        end
    end

    // Redirect pulse to the fetch unit and link strobes
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_redirect     <= 1'b0;
            o_redirect_pc  <= '0;
            o_cause        <= eit_pkg::CAUSE_NONE;
            bus.irq_ack    <= 1'b0;
            bus.vect_rd    <= 1'b0;
            bus.mask_wr    <= 1'b0;
            bus.mask_wdata <= '0;
            o_vect_data    <= '0;
            o_mask_rdata   <= '0;
        end else begin
            o_redirect     <= next_cause != eit_pkg::CAUSE_NONE;
            o_redirect_pc  <= next_vec;
            o_cause        <= next_cause;
            bus.irq_ack    <= next_cause == eit_pkg::CAUSE_EI;
            bus.vect_rd    <= i_vect_rd;
            bus.mask_wr    <= i_mask_wr;
            bus.mask_wdata <= i_mask_wdata;
            o_vect_data    <= bus.vect_data;
            o_mask_rdata   <= bus.mask_rdata;
        end
    end
endmodule

/* File: design/eit_ctrl_end.sv */
`timescale 1ns/100ps
// ****************************************************************
// Interrupt controller end: priority pick, vector index, priority mask
// ****************************************************************
module eit_ctrl_end (
    input  wire logic                                       i_sys_clk,
    input  wire logic                                       i_reset_n,
    input  wire logic [eit_pkg::SRC_N-1:0]                  i_src_req,
    input  wire logic [eit_pkg::SRC_N*eit_pkg::LVL_W-1:0]   i_src_level,
    output logic [eit_pkg::SRC_W-1:0]                       o_accepted_src,
    output logic [eit_pkg::LVL_W-1:0]                       o_mask,
    eit_if.ctrl                                             bus
);
    logic [eit_pkg::SRC_N-1:0]  qualified;
    logic [eit_pkg::LVL_W-1:0]  best_lvl;
    logic [eit_pkg::SRC_W-1:0]  best_src;
    logic                       best_hit;
    logic [eit_pkg::LVL_W-1:0]  accepted_lvl;
    logic [eit_pkg::LVL_W-1:0]  mask;
    logic [eit_pkg::PC_W-1:0]   vtab_addr;

    // Per source: requesting, not disabled, above the mask
    for (genvar g = 0; g < eit_pkg::SRC_N; g++) begin : g_qual
        assign qualified[g] = i_src_req[g]
            && (i_src_level[g*eit_pkg::LVL_W +: eit_pkg::LVL_W] != eit_pkg::LVL_DISABLE)
            && (i_src_level[g*eit_pkg::LVL_W +: eit_pkg::LVL_W] > mask);
    end

    // Highest level wins; equal levels go to the lowest index
    always_comb begin
        best_lvl = eit_pkg::LVL_DISABLE;
        best_src = '0;
        best_hit = 1'b0;
        for (int i = 0; i < eit_pkg::SRC_N; i++) begin
            if (qualified[i]
                && (!best_hit
                    || i_src_level[i*eit_pkg::LVL_W +: eit_pkg::LVL_W] > best_lvl)) begin
                best_lvl = i_src_level[i*eit_pkg::LVL_W +: eit_pkg::LVL_W];
                best_src = eit_pkg::SRC_W'(i);
                best_hit = 1'b1;
            end
        end
    end

    // Table entry address of the winning source
    assign vtab_addr = eit_pkg::VTAB_BASE
                     + (eit_pkg::PC_W'(best_src) * eit_pkg::VTAB_STEP);

    assign bus.mask_rdata = mask;
    assign o_mask         = mask;

    // Request line, vector index capture and mask update
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bus.irq_req    <= 1'b0;
            bus.vect_data  <= '0;
            accepted_lvl   <= eit_pkg::LVL_DISABLE;
            o_accepted_src <= '0;
            mask           <= eit_pkg::MASK_RST;
        end else begin
            bus.irq_req <= best_hit && !bus.irq_ack;
            if (bus.irq_ack && best_hit) begin
                bus.vect_data  <= vtab_addr[eit_pkg::VECT_W-1:0];
                accepted_lvl   <= best_lvl;
                o_accepted_src <= best_src;
            end
            if (bus.vect_rd) begin
                mask <= accepted_lvl;
            end else if (bus.mask_wr) begin
                mask <= bus.mask_wdata;
            end
        end
    end
endmodule

/* File: design/eit_sync.sv */
`timescale 1ns/100ps
// ****************************************************************
// Three-stage pin synchroniser; output changes once stages 2 and 3 agree
// ****************************************************************
module eit_sync (
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    input  wire logic i_pin,
    output logic      o_level
);
    logic stage1;
    logic stage2;
    logic stage3;
    logic agree;

    // Agreement of the last two stages
    assign agree = (stage2 == stage3);

    // Shift chain and filtered level; reset value is idle high
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stage1  <= 1'b1;
            stage2  <= 1'b1;
            stage3  <= 1'b1;
            o_level <= 1'b1;
        end else begin
            stage1 <= i_pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (agree) begin
                o_level <= stage3;
            end
        end
    end
endmodule

/* File: shared/eit_if.sv */
`timescale 1ns/100ps
// ****************************************************************
// Link between the CPU end and the interrupt controller end
// ****************************************************************
interface eit_if;
    logic                        irq_req;
    logic                        irq_ack;
    logic                        vect_rd;
    logic [eit_pkg::VECT_W-1:0]  vect_data;
    logic                        mask_wr;
    logic [eit_pkg::LVL_W-1:0]   mask_wdata;
    logic [eit_pkg::LVL_W-1:0]   mask_rdata;

    modport cpu (
        input  irq_req,
        input  vect_data,
        input  mask_rdata,
        output irq_ack,
        output vect_rd,
        output mask_wr,
        output mask_wdata
    );

    modport ctrl (
        output irq_req,
        output vect_data,
        output mask_rdata,
        input  irq_ack,
        input  vect_rd,
        input  mask_wr,
        input  mask_wdata
    );
endinterface

/* File: shared/eit_pkg.sv */
// ****************************************************************
// Shared constants for the exception entry and return unit
// ****************************************************************
package eit_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int PC_W    = 32;
    localparam int PSW_W   = 16;
    localparam int VECT_W  = 16;
    localparam int LVL_W   = 3;
    localparam int SRC_N   = 8;
    localparam int SRC_W   = 3;

    // ************************************************************
    // Status word field positions and reset value
    // ************************************************************
    localparam int PSW_C_BIT   = 0;
    localparam int PSW_IE_BIT  = 6;
    localparam int PSW_SM_BIT  = 7;
    localparam int PSW_BC_BIT  = 8;
    localparam int PSW_BIE_BIT = 14;
    localparam int PSW_BSM_BIT = 15;
    localparam logic [PSW_W-1:0] PSW_RST = 16'h0000;

    // ************************************************************
    // Vector entry addresses, one per cause except return
    // ************************************************************
    localparam logic [PC_W-1:0] VEC_RESET = 32'h0000_0000;
    localparam logic [PC_W-1:0] VEC_SBI   = 32'h0000_0010;
    localparam logic [PC_W-1:0] VEC_RIE   = 32'h0000_0020;
    localparam logic [PC_W-1:0] VEC_AE    = 32'h0000_0030;
    localparam logic [PC_W-1:0] VEC_TRAP  = 32'h0000_0040;
    localparam logic [PC_W-1:0] VEC_EI    = 32'h0000_0080;

    // ************************************************************
    // Peripheral vector table and priority levels
    // ************************************************************
    localparam logic [PC_W-1:0]  VTAB_BASE   = 32'h0000_0094;
    localparam logic [PC_W-1:0]  VTAB_STEP   = 32'h0000_0004;
    localparam logic [LVL_W-1:0] LVL_DISABLE = 3'h0;
    localparam logic [LVL_W-1:0] MASK_RST    = 3'h0;

    // ************************************************************
    // Access sizes and causes
    // ************************************************************
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    typedef enum logic [2:0] {
        CAUSE_NONE  = 3'b000,
        CAUSE_RESET = 3'b001,
        CAUSE_SBI   = 3'b010,
        CAUSE_RIE   = 3'b011,
        CAUSE_AE    = 3'b100,
        CAUSE_TRAP  = 3'b101,
        CAUSE_EI    = 3'b110,
        CAUSE_RTE   = 3'b111
    } eit_cause_type;

endpackage
